// [rtl/swpm_ctrl.sv]
// sleep/wake power mode controller with real-time counter and sleep memory
//
// Notes on behaviour
// - awake and asleep states joined by power-down and power-up sequences.
// - writing the sleep bit of the control register starts power-down.
// - pin or timer wakeup starts power-up from asleep.
// - wakeup acts only in asleep; ignored as trigger while awake.
// - wakeup seen during power-down is held and acted on at asleep.
// - pin wakes on active or inactive level, chosen by software.
// - 64-bit counter reaching programmed compare value wakes the chip.
// - awake, counter adds one every main clock tick.
// - asleep, counter may switch to the slow 31,250 Hz tick.
// - on slow ticks the counter adds a programmed increment.
// - asleep powers down core and most peripherals; awake powers all.
// - 128-byte retained memory available to software across sleep.
// - power-good lost during either transition issues system reset.
// - switched io supply output on only while awake.
// - watchdog enabled and clocked only while awake.
//
// Our own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ns
module swpm_ctrl
#(
  parameter int SEQ_CYC = swpm_pkg::SEQ_STEP_CYC,
  parameter int DIV_CYC = swpm_pkg::SLOW_DIV
)
(
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  input  wire swpm_pkg::swpm_bus_type bus,
  output logic [31:0]               rdata,
  input  wire logic                 wake_pin,
  input  wire logic                 power_good,
  output swpm_pkg::swpm_pwr_type    pwr,
  output logic                      switched_io_supply_out,
  output logic                      irq
);

  // -------------------------------------------------------------------------
  // declarations
  // -------------------------------------------------------------------------
  swpm_pkg::swpm_state_type state_reg;
  logic [1:0]         pin_sync_reg;
  logic [1:0]         pg_sync_reg;
  logic [3:0]         wcfg_reg;
  logic [63:0]        cmp_reg;
  logic [63:0]        cnt_reg;
  logic [63:0]        cnt_next;
  logic [31:0]        incr_reg;
  logic [31:0]        dsm_reg [swpm_pkg::DSM_WORDS];
  logic [15:0]        seq_cnt_reg;
  logic [15:0]        div_cnt_reg;
  logic               slow_tick;
  logic               wake_pend_reg;
  logic               wake_ev;
  logic               match;
  logic               seq_done;
  logic               sleep_req;
  logic               slow_mode;
  logic [swpm_pkg::IRQ_W-1:0] ist_reg;
  logic [swpm_pkg::IRQ_W-1:0] ien_reg;
  logic [swpm_pkg::IRQ_W-1:0] iset;
  logic [swpm_pkg::IRQ_W-1:0] iclr;
  logic               pin_act;
  logic               in_trans;

  // -------------------------------------------------------------------------
  // input synchronisers
  // -------------------------------------------------------------------------
  // pins are asynchronous, two flops before any use
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      pin_sync_reg <= 2'h0;
      pg_sync_reg  <= 2'h3;
    end
    else
    begin
      pin_sync_reg <= {pin_sync_reg[0], wake_pin};
      pg_sync_reg  <= {pg_sync_reg[0], power_good};
    end
  end

  // -------------------------------------------------------------------------
  // wake sources
  // -------------------------------------------------------------------------
  // level compare on synced pin, polarity picked by software
  assign pin_act = wcfg_reg[swpm_pkg::WCFG_PIN_EN_BIT]
    & (pin_sync_reg[1] == wcfg_reg[swpm_pkg::WCFG_PIN_POL_BIT]);
  // >= so a coarse slow increment cannot step over the target
  assign match = wcfg_reg[swpm_pkg::WCFG_TMR_EN_BIT]
    & (cnt_reg >= cmp_reg);
  assign wake_ev   = pin_act | match;
  assign sleep_req = bus.wr & (bus.addr == swpm_pkg::CTRL_OFS)
    & bus.wdata[swpm_pkg::CTRL_SLEEP_BIT];
  assign in_trans  = (state_reg == swpm_pkg::ST_PWR_DOWN)
    | (state_reg == swpm_pkg::ST_PWR_UP);
  assign seq_done  = (seq_cnt_reg == 16'(SEQ_CYC - 1));

  // wake seen during power-down is latched until asleep is reached
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      wake_pend_reg <= 1'b0;
    else if (state_reg == swpm_pkg::ST_PWR_DOWN && wake_ev)
      wake_pend_reg <= 1'b1;
    else if (state_reg != swpm_pkg::ST_PWR_DOWN)
      wake_pend_reg <= 1'b0;
  end

  // -------------------------------------------------------------------------
  // power state machine
  // -------------------------------------------------------------------------
  // sequence step counter runs only in the transition states
  always_ff @(posedge clk)
  begin
    if (sys_rst || !in_trans || seq_done)
      seq_cnt_reg <= 16'h0000;
    else
      seq_cnt_reg <= seq_cnt_reg + 16'h0001;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      state_reg <= swpm_pkg::ST_AWAKE;
    else
    begin
      case (state_reg)
        swpm_pkg::ST_AWAKE:
          // wake sources are not looked at here
          if (sleep_req)
            state_reg <= swpm_pkg::ST_PWR_DOWN;
        swpm_pkg::ST_PWR_DOWN:
          if (!pg_sync_reg[1])
            state_reg <= swpm_pkg::ST_RESET;
          else if (seq_done)
            state_reg <= swpm_pkg::ST_ASLEEP;
        swpm_pkg::ST_ASLEEP:
          if (wake_ev || wake_pend_reg)
            state_reg <= swpm_pkg::ST_PWR_UP;
        swpm_pkg::ST_PWR_UP:
          if (!pg_sync_reg[1])
            state_reg <= swpm_pkg::ST_RESET;
          else if (seq_done)
            state_reg <= swpm_pkg::ST_AWAKE;
        swpm_pkg::ST_RESET:
          // one reset pulse, then restart as after power-on
          state_reg <= swpm_pkg::ST_AWAKE;
        default:
          state_reg <= swpm_pkg::ST_AWAKE;
      endcase
    end
  end

  // -------------------------------------------------------------------------
  // supply and domain outputs
  // -------------------------------------------------------------------------
  // registered so supply switches never glitch
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      pwr                    <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
      switched_io_supply_out <= 1'b1;
    end
    else
    begin
      pwr.core_on      <= (state_reg != swpm_pkg::ST_ASLEEP);
      pwr.periph_on    <= (state_reg != swpm_pkg::ST_ASLEEP);
      pwr.io_supply_on <= (state_reg == swpm_pkg::ST_AWAKE);
      pwr.watchdog_en  <= (state_reg == swpm_pkg::ST_AWAKE);
      pwr.sys_reset    <= (state_reg == swpm_pkg::ST_RESET);
      switched_io_supply_out <= (state_reg == swpm_pkg::ST_AWAKE);
    end
  end

  // -------------------------------------------------------------------------
  // real-time counter
  // -------------------------------------------------------------------------
  assign slow_mode = (state_reg == swpm_pkg::ST_ASLEEP)
    & wcfg_reg[swpm_pkg::WCFG_SLOW_EN_BIT];
  assign slow_tick = (div_cnt_reg == 16'(DIV_CYC - 1));

  // divider makes the slow tick enable from the main clock
  always_ff @(posedge clk)
  begin
    if (sys_rst || !slow_mode || slow_tick)
      div_cnt_reg <= 16'h0000;
    else
      div_cnt_reg <= div_cnt_reg + 16'h0001;
  end

  always_comb
  begin
    if (!slow_mode)
      cnt_next = cnt_reg + 64'h1;
    else if (slow_tick)
      cnt_next = cnt_reg + {32'h0, incr_reg};
    else
      cnt_next = cnt_reg;
  end

  // software writes override counting in that cycle
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      cnt_reg <= 64'h0;
    else if (bus.wr && bus.addr == swpm_pkg::CNT_LO_OFS)
      cnt_reg <= {cnt_reg[63:32], bus.wdata};
    else if (bus.wr && bus.addr == swpm_pkg::CNT_HI_OFS)
      cnt_reg <= {bus.wdata, cnt_reg[31:0]};
    else
      cnt_reg <= cnt_next;
  end

  // -------------------------------------------------------------------------
  // configuration registers and retained memory
  // -------------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      wcfg_reg <= swpm_pkg::WAKE_CFG_RST;
      cmp_reg  <= swpm_pkg::CMP_RST;
      incr_reg <= swpm_pkg::INCR_RST;
      ien_reg  <= '0;
    end
    else if (bus.wr)
    begin
      case (bus.addr)
        swpm_pkg::WAKE_CFG_OFS: wcfg_reg <= bus.wdata[3:0];
        swpm_pkg::CMP_LO_OFS:   cmp_reg[31:0] <= bus.wdata;
        swpm_pkg::CMP_HI_OFS:   cmp_reg[63:32] <= bus.wdata;
        swpm_pkg::INCR_OFS:     incr_reg <= bus.wdata;
        swpm_pkg::IRQ_EN_OFS:   ien_reg <= bus.wdata[swpm_pkg::IRQ_W-1:0];
        default:                ;
      endcase
    end
  end

  // retained words are not reset by a sleep cycle, only by sys_rst
  genvar gi;
  generate
    for (gi = 0; gi < swpm_pkg::DSM_WORDS; gi++)
    begin : g_dsm
      always_ff @(posedge clk)
      begin
        if (sys_rst)
          dsm_reg[gi] <= 32'h0;
        else if (bus.wr && bus.addr == 8'(swpm_pkg::DSM_BASE_OFS + gi * 4))
          dsm_reg[gi] <= bus.wdata;
      end
    end
  endgenerate

  // -------------------------------------------------------------------------
  // interrupts
  // -------------------------------------------------------------------------
  assign iset = {match,
                 state_reg == swpm_pkg::ST_PWR_DOWN && seq_done,
                 state_reg == swpm_pkg::ST_PWR_UP && seq_done};
  assign iclr = (bus.wr && bus.addr == swpm_pkg::IRQ_CLR_OFS)
    ? bus.wdata[swpm_pkg::IRQ_W-1:0] : '0;

  // set beats clear in the same cycle
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      ist_reg <= '0;
    else
      ist_reg <= (ist_reg & ~iclr) | iset;
  end

  assign irq = |(ist_reg & ien_reg);

  // -------------------------------------------------------------------------
  // read data
  // -------------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      rdata <= 32'h0;
    else if (bus.rd)
    begin
      if (bus.addr >= swpm_pkg::DSM_BASE_OFS
          && bus.addr <= swpm_pkg::DSM_TOP_OFS)
        rdata <= dsm_reg[bus.addr[6:2]];
      else
      begin
        case (bus.addr)
          swpm_pkg::WAKE_CFG_OFS: rdata <= {28'h0, wcfg_reg};
          swpm_pkg::CMP_LO_OFS:   rdata <= cmp_reg[31:0];
          swpm_pkg::CMP_HI_OFS:   rdata <= cmp_reg[63:32];
          swpm_pkg::CNT_LO_OFS:   rdata <= cnt_reg[31:0];
          swpm_pkg::CNT_HI_OFS:   rdata <= cnt_reg[63:32];
          swpm_pkg::INCR_OFS:     rdata <= incr_reg;
          swpm_pkg::STATUS_OFS:   rdata <= {28'h0, wake_pend_reg, state_reg};
          swpm_pkg::IRQ_STAT_OFS: rdata <= {29'h0, ist_reg};
          swpm_pkg::IRQ_EN_OFS:   rdata <= {29'h0, ien_reg};
          default:                rdata <= 32'h0;
        endcase
      end
    end
    else
      rdata <= 32'h0;
  end

  // -------------------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------------------
  sleep_start_a: assert property (@(posedge clk)
    disable iff (sys_rst)
    state_reg == swpm_pkg::ST_AWAKE && sleep_req
    |=> state_reg == swpm_pkg::ST_PWR_DOWN)
    else $error("sleep request not taken");
  awake_hold_a: assert property (@(posedge clk)
    disable iff (sys_rst)
    state_reg == swpm_pkg::ST_AWAKE && !sleep_req
    |=> state_reg == swpm_pkg::ST_AWAKE)
    else $error("left awake without request");
  wake_go_a: assert property (@(posedge clk)
    disable iff (sys_rst)
    state_reg == swpm_pkg::ST_ASLEEP && wake_ev
    |=> state_reg == swpm_pkg::ST_PWR_UP)
    else $error("wake not acted on");
  pend_wake_a: assert property (@(posedge clk)
    disable iff (sys_rst)
    state_reg == swpm_pkg::ST_ASLEEP && wake_pend_reg
    |=> state_reg == swpm_pkg::ST_PWR_UP)
    else $error("pending wake lost");
  pg_reset_a: assert property (@(posedge clk)
    disable iff (sys_rst)
    in_trans && !pg_sync_reg[1] |=> ##1 pwr.sys_reset)
    else $error("no reset on power loss");
  io_supply_a: assert property (@(posedge clk)
    disable iff (sys_rst)
    switched_io_supply_out |-> $past(state_reg) == swpm_pkg::ST_AWAKE)
    else $error("io supply on outside awake");
  wdog_en_a: assert property (@(posedge clk)
    disable iff (sys_rst)
    pwr.watchdog_en == switched_io_supply_out)
    else $error("watchdog enable outside awake");
  fast_cnt_a: assert property (@(posedge clk)
    disable iff (sys_rst)
    !slow_mode && !bus.wr |=> cnt_reg == $past(cnt_reg) + 64'h1)
    else $error("counter did not tick");
  slow_cnt_a: assert property (@(posedge clk)
    disable iff (sys_rst)
    slow_mode && slow_tick && !bus.wr
    |=> cnt_reg == $past(cnt_reg) + {32'h0, $past(incr_reg)})
    else $error("slow increment wrong");

  sleep_cycle_c: cover property (@(posedge clk)
    state_reg == swpm_pkg::ST_ASLEEP ##1 state_reg == swpm_pkg::ST_PWR_UP);
  pend_wake_c: cover property (@(posedge clk) wake_pend_reg);
  pg_reset_c: cover property (@(posedge clk) pwr.sys_reset);
  slow_tick_c: cover property (@(posedge clk) slow_mode && slow_tick);

endmodule

// [rtl/swpm_pkg.sv]
// package of constants and types for the sleep/wake power mode controller
package swpm_pkg;

  // -------------------------------------------------------------------------
  // register offsets (byte addresses, one 32-bit word every four bytes)
  // -------------------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS       = 8'h00;
  localparam logic [7:0] WAKE_CFG_OFS   = 8'h04;
  localparam logic [7:0] CMP_LO_OFS     = 8'h08;
  localparam logic [7:0] CMP_HI_OFS     = 8'h0C;
  localparam logic [7:0] CNT_LO_OFS     = 8'h10;
  localparam logic [7:0] CNT_HI_OFS     = 8'h14;
  localparam logic [7:0] INCR_OFS       = 8'h18;
  localparam logic [7:0] STATUS_OFS     = 8'h1C;
  localparam logic [7:0] IRQ_STAT_OFS   = 8'h20;
  localparam logic [7:0] IRQ_EN_OFS     = 8'h24;
  localparam logic [7:0] IRQ_CLR_OFS    = 8'h28;
  localparam logic [7:0] DSM_BASE_OFS   = 8'h80;
  localparam logic [7:0] DSM_TOP_OFS    = 8'hFC;

  // -------------------------------------------------------------------------
  // field positions
  // -------------------------------------------------------------------------
  localparam int CTRL_SLEEP_BIT    = 0;
  localparam int WCFG_PIN_EN_BIT   = 0;
  localparam int WCFG_PIN_POL_BIT  = 1;
  localparam int WCFG_TMR_EN_BIT   = 2;
  localparam int WCFG_SLOW_EN_BIT  = 3;
  localparam int IRQ_WAKE_BIT      = 0;
  localparam int IRQ_SLEPT_BIT     = 1;
  localparam int IRQ_MATCH_BIT     = 2;
  localparam int IRQ_W             = 3;

  // -------------------------------------------------------------------------
  // reset values and timing
  // -------------------------------------------------------------------------
  localparam logic [3:0]  WAKE_CFG_RST = 4'h0;
  localparam logic [31:0] INCR_RST     = 32'h0000_0C80;
  localparam logic [63:0] CMP_RST      = 64'hFFFF_FFFF_FFFF_FFFF;
  localparam int CLK_HZ      = 100_000_000;
  localparam int SLOW_HZ     = 31_250;
  localparam int SLOW_DIV    = CLK_HZ / SLOW_HZ;
  localparam int SEQ_STEP_NS = 100;
  localparam int SEQ_STEP_CYC = (SEQ_STEP_NS * (CLK_HZ / 1_000_000)
                                 + 999) / 1000;
  localparam int DSM_WORDS   = 32;

  // power states, Gray coded along the loop
  typedef enum logic [2:0] {
    ST_AWAKE    = 3'b000,
    ST_PWR_DOWN = 3'b001,
    ST_ASLEEP   = 3'b011,
    ST_PWR_UP   = 3'b010,
    ST_RESET    = 3'b110
  } swpm_state_type;

  // supply and domain controls
  typedef struct packed {
    logic core_on;
    logic periph_on;
    logic io_supply_on;
    logic watchdog_en;
    logic sys_reset;
  } swpm_pwr_type;

  // register bus request
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } swpm_bus_type;

endpackage

// [tb/swpm_wake_src.sv]
// far-side model: wake pin and supply power-good source
`timescale 1ns/1ns
module swpm_wake_src
(
  input  wire logic clk,
  input  wire logic pin_cmd,
  input  wire logic pg_cmd,
  output logic      wake_pin,
  output logic      power_good
);
  // ---------------------------------------------------------------------
  // pin and supply levels
  // ---------------------------------------------------------------------
  // known levels from time zero, so the design never sees an unknown
  initial
  begin
    wake_pin   = 1'b0;
    power_good = 1'b1;
  end

  // only the supply left on through sleep is modelled, so it stays good
  // unless a test drops it on purpose
  // levels move only just after an edge; the design syncs them anyway
  always @(posedge clk)
  begin
    wake_pin   <= pin_cmd;
    power_good <= pg_cmd;
  end
endmodule

// [tb/swpm_ctrl_bench.sv]
// self-checking bench for the sleep/wake power mode controller
`timescale 1ns/1ns
module swpm_ctrl_bench;
  // ---------------------------------------------------------------------
  // signals and design
  // ---------------------------------------------------------------------
  localparam int SEQ = 10;
  localparam int DIV = 4;

  logic                   clk;
  logic                   sys_rst;
  swpm_pkg::swpm_bus_type bus;
  logic [31:0]            rdata;
  logic                   wake_pin;
  logic                   power_good;
  swpm_pkg::swpm_pwr_type pwr;
  logic                   io_out;
  logic                   irq;
  logic                   pin_cmd;
  logic                   pg_cmd;
  logic [31:0]            v;
  logic [31:0]            v2;
  int                     num_errors;
  int                     tests_run;
  int                     n;

  initial clk = 1'b0;
  always #5 clk = ~clk;

  // small divider keeps the slow tick every four cycles
  swpm_ctrl #(.SEQ_CYC(SEQ), .DIV_CYC(DIV)) dut
  (
    .clk                    (clk),
    .sys_rst                (sys_rst),
    .bus                    (bus),
    .rdata                  (rdata),
    .wake_pin               (wake_pin),
    .power_good             (power_good),
    .pwr                    (pwr),
    .switched_io_supply_out (io_out),
    .irq                    (irq)
  );

  swpm_wake_src far
  (
    .clk        (clk),
    .pin_cmd    (pin_cmd),
    .pg_cmd     (pg_cmd),
    .wake_pin   (wake_pin),
    .power_good (power_good)
  );

  // ---------------------------------------------------------------------
  // bus, compare and closing tasks
  // ---------------------------------------------------------------------
  // write strobe one cycle; ends a step past the edge so flags settle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus.addr  <= a;
    bus.wdata <= d;
    bus.wr    <= 1'b1;
    @(posedge clk);
    bus.wr <= 1'b0;
    #1;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    bus.addr <= a;
    bus.rd   <= 1'b1;
    @(posedge clk);
    bus.rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic chk32(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk1(input string nm, input logic e, input logic g);
    tests_run++;
    if (g !== e)
    begin
      num_errors++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask

  // bounded wait on the core domain, checked at the end
  task automatic wait_core(input logic lvl, input int lim);
    int k;
    k = 0;
    while (pwr.core_on !== lvl && k < lim)
    begin
      @(posedge clk);
      #1;
      k++;
    end
    chk1("core_on", lvl, pwr.core_on);
  endtask

  // core comes back at the start of power-up; awake only ten cycles later,
  // so a sleep request before this would be refused
  task automatic wait_awake(input int lim);
    int k;
    k = 0;
    while (io_out !== 1'b1 && k < lim)
    begin
      @(posedge clk);
      #1;
      k++;
    end
    chk1("io_out", 1'b1, io_out);
  endtask

  task automatic tend(input string nm);
    $display("test %s done", nm);
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // watchdog well beyond the few hundred cycles the tests need
  initial
  begin
    #300000;
    num_errors++;
    report_and_stop;
  end

  // ---------------------------------------------------------------------
  // test sequence
  // ---------------------------------------------------------------------
  initial
  begin
    sys_rst    = 1'b1;
    bus        = '0;
    pin_cmd    = 1'b0;
    pg_cmd     = 1'b1;
    num_errors = 0;
    tests_run  = 0;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    // reset values, unmapped read, free-running count
    rd(swpm_pkg::STATUS_OFS, v);
    chk32("status", 32'h0000_0000, v);
    rd(swpm_pkg::INCR_OFS, v);
    chk32("incr", 32'h0000_0C80, v);
    rd(swpm_pkg::CMP_HI_OFS, v);
    chk32("cmp_hi", 32'hFFFF_FFFF, v);
    rd(8'h30, v);
    chk32("unmapped", 32'h0000_0000, v);
    chk1("watchdog_en", 1'b1, pwr.watchdog_en);
    chk1("io_out", 1'b1, io_out);
    chk1("irq", 1'b0, irq);
    rd(swpm_pkg::CNT_LO_OFS, v);
    rd(swpm_pkg::CNT_LO_OFS, v2);
    chk32("count step", v + 32'h0000_0002, v2);
    wr(swpm_pkg::CNT_HI_OFS, 32'h0000_0005);
    rd(swpm_pkg::CNT_HI_OFS, v);
    chk32("cnt_hi", 32'h0000_0005, v);
    tend("reset");
    // timer wake on slow ticks; 8192 cycles would be needed without them
    wr(swpm_pkg::DSM_BASE_OFS, 32'hA5A5_0001);
    wr(swpm_pkg::DSM_TOP_OFS, 32'h0000_5A5A);
    wr(swpm_pkg::IRQ_EN_OFS, 32'h0000_0007);
    wr(swpm_pkg::INCR_OFS, 32'h0000_0100);
    wr(swpm_pkg::CNT_HI_OFS, 32'h0000_0000);
    wr(swpm_pkg::CNT_LO_OFS, 32'h0000_0000);
    wr(swpm_pkg::CMP_HI_OFS, 32'h0000_0000);
    wr(swpm_pkg::CMP_LO_OFS, 32'h0000_2000);
    wr(swpm_pkg::WAKE_CFG_OFS, 32'h0000_000C);
    wr(swpm_pkg::CTRL_OFS, 32'h0000_0001);
    wait_core(1'b0, 40);
    chk1("periph_on", 1'b0, pwr.periph_on);
    chk1("watchdog_en", 1'b0, pwr.watchdog_en);
    chk1("io_out", 1'b0, io_out);
    chk1("io_supply_on", 1'b0, pwr.io_supply_on);
    rd(swpm_pkg::STATUS_OFS, v);
    chk32("state", 32'h0000_0003, v & 32'h0000_0007);
    wait_core(1'b1, 400);
    wait_awake(40);
    chk1("io_out", 1'b1, io_out);
    rd(swpm_pkg::CNT_LO_OFS, v);
    chk1("match", 1'b1, v >= 32'h0000_2000);
    rd(swpm_pkg::IRQ_STAT_OFS, v);
    chk32("irq_stat", 32'h0000_0007, v);
    chk1("irq", 1'b1, irq);
    wr(swpm_pkg::CMP_HI_OFS, 32'hFFFF_FFFF);
    wr(swpm_pkg::IRQ_EN_OFS, 32'h0000_0000);
    chk1("irq masked", 1'b0, irq);
    wr(swpm_pkg::IRQ_CLR_OFS, 32'h0000_0007);
    rd(swpm_pkg::IRQ_STAT_OFS, v);
    chk32("irq_stat", 32'h0000_0000, v);
    wr(swpm_pkg::IRQ_EN_OFS, 32'h0000_0007);
    chk1("irq", 1'b0, irq);
    rd(swpm_pkg::DSM_BASE_OFS, v);
    chk32("dsm first", 32'hA5A5_0001, v);
    rd(swpm_pkg::DSM_TOP_OFS, v);
    chk32("dsm last", 32'h0000_5A5A, v);
    tend("timer wake");
    // pin wake on each chosen level; ignored while awake
    for (int p = 0; p < 2; p++)
    begin
      wr(swpm_pkg::WAKE_CFG_OFS, {30'h0, p[0], 1'b1});
      @(posedge clk);
      pin_cmd <= p[0];
      repeat (20) @(posedge clk);
      rd(swpm_pkg::STATUS_OFS, v);
      chk32("awake stays", 32'h0000_0000, v);
      @(posedge clk);
      pin_cmd <= ~p[0];
      repeat (4) @(posedge clk);
      wr(swpm_pkg::CTRL_OFS, 32'h0000_0001);
      wait_core(1'b0, 40);
      repeat (30) @(posedge clk);
      #1;
      chk1("asleep holds", 1'b0, pwr.core_on);
      @(posedge clk);
      pin_cmd <= p[0];
      wait_core(1'b1, 40);
      wait_awake(40);
      @(posedge clk);
      pin_cmd <= ~p[0];
      repeat (4) @(posedge clk);
    end
    tend("pin wake");
    // short pin pulse inside power-down must still wake at asleep
    wr(swpm_pkg::CTRL_OFS, 32'h0000_0001);
    @(posedge clk);
    pin_cmd <= 1'b1;
    repeat (3) @(posedge clk);
    pin_cmd <= 1'b0;
    wait_core(1'b0, 40);
    wait_core(1'b1, 40);
    wait_awake(40);
    tend("latched wake");
    // supply loss inside power-down forces a system reset pulse
    repeat (4) @(posedge clk);
    wr(swpm_pkg::CTRL_OFS, 32'h0000_0001);
    @(posedge clk);
    pg_cmd <= 1'b0;
    n = 0;
    while (pwr.sys_reset !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk1("sys_reset", 1'b1, pwr.sys_reset);
    @(posedge clk);
    pg_cmd <= 1'b1;
    repeat (6) @(posedge clk);
    rd(swpm_pkg::STATUS_OFS, v);
    chk32("state", 32'h0000_0000, v & 32'h0000_0007);
    chk1("core_on", 1'b1, pwr.core_on);
    tend("power fail");
    report_and_stop;
  end
endmodule
